// ---- core_model.sv ----
// core stand-in: takes a normal request only with its status word enabled
// assumes request lines are levels held until the handler clears them
`timescale 1ns/1ps
module core_model (
  input wire logic sys_clk_i,
  input wire logic nrst_i,
  input wire logic irq_i,
  input wire logic nmi_i,
  input wire logic ie_i,
  output int taken_o,
  output int nmi_taken_o
);
  logic busy;
  logic nmi_q;
  // busy until the line drops, so one entry per request
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      busy <= 1'h0;
      taken_o <= 0;
    end else if (irq_i && ie_i && !busy) begin
      busy <= 1'h1;
      taken_o <= taken_o + 1;
    end else if (!irq_i) begin
      busy <= 1'h0;
    end
  end
  // no status word gate on this path
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      nmi_q <= 1'h0;
      nmi_taken_o <= 0;
    end else begin
      nmi_q <= nmi_i;
      if (nmi_i && !nmi_q) nmi_taken_o <= nmi_taken_o + 1;
    end
  end
endmodule // core_model

// ---- intc_bank.sv ----
// one group of three bit registers with plain, set and clear stores
// assumes decoder drives at most one select per cycle
`timescale 1ns/1ps
module intc_bank
  import intc_pkg::*;
(
  input wire logic sys_clk_i,
  input wire logic nrst_i,
  intc_bank_if.bank b
);
  logic [31:0] int_r;
  logic [63:0] ext_r;

  function automatic logic [31:0] upd(input logic [31:0] cur,
                                      input write_kind_t k,
                                      input logic [31:0] d);
    logic [31:0] r;
    r = cur;
    unique case (k)
      WR_PLAIN: r = d;
      WR_SET: r = cur | d;
      WR_CLEAR: r = cur & ~d;
      default: r = cur;
    endcase
    return r;
  endfunction

  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      int_r <= REG_RESET;
    end else if (b.wr && b.sel_int) begin
      // reserved bits held at zero
      int_r <= upd(int_r, b.kind, b.data) & INT_VALID_BITS;
    end
  end

  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      ext_r <= {REG_RESET, REG_RESET};
    end else if (b.wr && b.sel_low) begin
      ext_r[31:0] <= upd(ext_r[31:0], b.kind, b.data);
    end else if (b.wr && b.sel_high) begin
      ext_r[63:32] <= upd(ext_r[63:32], b.kind, b.data);
    end
  end

  assign b.int_q = int_r;
  assign b.ext_q = ext_r;
endmodule // intc_bank

// ---- intc_bank_if.sv ----
// interface carrying one decoded store from the bus decoder to a bank
// assumes a single clock domain shared with the decoder
`timescale 1ns/1ps
interface intc_bank_if;
  import intc_pkg::*;
  logic sel_int;
  logic sel_low;
  logic sel_high;
  logic wr;
  write_kind_t kind;
  logic [31:0] data;
  logic [31:0] int_q;
  logic [63:0] ext_q;
  modport ctrl (
    output sel_int, sel_low, sel_high, wr, kind, data,
    input int_q, ext_q
  );
  modport bank (
    input sel_int, sel_low, sel_high, wr, kind, data,
    output int_q, ext_q
  );
endinterface

// ---- intc_pkg.sv ----
// package for the normal interrupt aggregator: offsets, field layout, resets
// assumes word addressing of a peripheral window relative to its base
package intc_pkg;
  localparam int ADDR_W = 16;
  localparam int EXT_N = 64;
  localparam int INT_N = 4;
  // internal word field positions
  localparam int TIMER_ZERO_BIT = 0;
  localparam int TIMER_ONE_BIT = 1;
  localparam int TIMER_TWO_BIT = 2;
  localparam int PERF_MONITOR_BIT = 16;
  localparam logic [31:0] INT_VALID_BITS = 32'h0001_0007;
  localparam logic [31:0] REG_RESET = 32'h0000_0000;
  // register groups: base offset, external low at +0x100, high at +0x108
  localparam logic [ADDR_W-1:0] OFS_PENDING_GROUP = 16'h0000;
  localparam logic [ADDR_W-1:0] OFS_ENABLE_GROUP = 16'h0200;
  localparam logic [ADDR_W-1:0] OFS_FORCE_GROUP = 16'h0400;
  localparam logic [ADDR_W-1:0] OFS_FORCE_SETTER = 16'h0600;
  localparam logic [ADDR_W-1:0] OFS_FORCE_CLEARER = 16'h0800;
  localparam logic [ADDR_W-1:0] OFS_ENABLE_SETTER = 16'h0a00;
  localparam logic [ADDR_W-1:0] OFS_ENABLE_CLEARER = 16'h0c00;
  localparam logic [ADDR_W-1:0] OFS_EXT_LOW = 16'h0100;
  localparam logic [ADDR_W-1:0] OFS_EXT_HIGH = 16'h0108;
  // access size encoding on the bus
  localparam logic [1:0] SIZE_WORD = 2'h2;
  typedef enum logic [1:0] {
    WR_PLAIN,
    WR_SET,
    WR_CLEAR
  } write_kind_t;
endpackage

// ---- normal_interrupt_aggregator.sv ----
// normal interrupt aggregator: pending, enable and force registers
// assumes sources are asynchronous levels; bus is a simple word port
//
// Overview of operation
// - take 64 external lines, three timer lines and one perf monitor line
// - each source owns one enable bit and one force bit
// - a raised source sets its pending bit and, if its enable bit is set, requests the core
// - core takes request only when its status word enables interrupts
// - no priority between sources; software chooses via enables
// - separate non-maskable input passes straight to the core
// - every request here is a normal interrupt, never debug
// - registers grouped in threes: one internal, two external words
// - internal bits 0..2 timers, 16 perf monitor, others read zero
// - external sources 31..0 in low word, 63..32 in high word
// - three pending words are read-only and reset to zero
// - enable words read/write, same bit layout, reset zero
// - enable setter store sets only the selected bits
// - enable clearer store clears only the selected bits
// - software may assert any source by setting its force bit
// - force words read/write, reset zero, same layout
// - force setter and clearer touch only selected force bits
// - only uncached word accesses to a register; others bus error
`timescale 1ns/1ps
module normal_interrupt_aggregator
  import intc_pkg::*;
(
  input wire logic sys_clk_i,
  input wire logic nrst_i,
  input wire logic [EXT_N-1:0] ext_irq_i,
  input wire logic timer_zero_source_i,
  input wire logic timer_one_source_i,
  input wire logic timer_two_source_i,
  input wire logic perf_monitor_source_i,
  input wire logic ext_ctrl_irq_i,
  input wire logic req_i,
  input wire logic we_i,
  input wire logic cached_i,
  input wire logic [1:0] size_i,
  input wire logic [ADDR_W-1:0] addr_i,
  input wire logic [31:0] wdata_i,
  output logic ack_o,
  output logic err_o,
  output logic [31:0] rdata_o,
  output logic core_irq_o,
  output logic core_nmi_o
);
  logic [EXT_N-1:0] ext_s1;
  logic [EXT_N-1:0] ext_s2;
  logic [INT_N-1:0] int_s1;
  logic [INT_N-1:0] int_s2;
  logic nmi_s1;
  logic nmi_s2;
  logic [31:0] int_src;
  logic [31:0] int_pending;
  logic [63:0] ext_pending;
  logic [31:0] int_pending_q;
  logic [63:0] ext_pending_q;
  logic [ADDR_W-1:0] grp;
  logic [ADDR_W-1:0] sub;
  logic sub_int;
  logic sub_low;
  logic sub_high;
  logic hit;
  logic is_pend;
  logic is_en;
  logic is_force;
  logic legal;
  write_kind_t kind;
  logic [31:0] next_rdata;
  logic [31:0] pend_word;
  logic [31:0] en_word;
  logic [31:0] fo_word;
  logic sub_hit;
  logic grp_hit;
  logic wr_req;
  logic rd_req;
  logic int_any;
  logic ext_any;

  intc_bank_if en_if ();
  intc_bank_if fo_if ();

  // two-stage synchronisers on every asynchronous source
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      ext_s1 <= '0;
      ext_s2 <= '0;
    end else begin
      ext_s1 <= ext_irq_i;
      ext_s2 <= ext_s1;
    end
  end

  // timers and perf monitor, packed low to high
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      int_s1 <= '0;
      int_s2 <= '0;
    end else begin
      int_s1 <= {perf_monitor_source_i, timer_two_source_i,
                 timer_one_source_i, timer_zero_source_i};
      int_s2 <= int_s1;
    end
  end

  // the outside controller's line is synchronised like any source
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      nmi_s1 <= 1'b0;
      nmi_s2 <= 1'b0;
    end else begin
      nmi_s1 <= ext_ctrl_irq_i;
      nmi_s2 <= nmi_s1;
    end
  end

  always_comb begin
    int_src = '0;
    int_src[TIMER_ZERO_BIT] = int_s2[0];
    int_src[TIMER_ONE_BIT] = int_s2[1];
    int_src[TIMER_TWO_BIT] = int_s2[2];
    int_src[PERF_MONITOR_BIT] = int_s2[3];
  end

  // level-sensitive: pending follows source or force, no latch-and-clear
  assign int_pending = (int_src | fo_if.int_q) & INT_VALID_BITS;
  assign ext_pending = ext_s2 | fo_if.ext_q;

  // software reads a registered copy; the request uses the live term
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      int_pending_q <= REG_RESET;
    end else begin
      int_pending_q <= int_pending;
    end
  end

  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      ext_pending_q <= {REG_RESET, REG_RESET};
    end else begin
      ext_pending_q <= ext_pending;
    end
  end

  // enabled pending terms, internal word reduced on its own, the two external words as one 64-bit term
  assign int_any = |(int_pending & en_if.int_q);
  assign ext_any = |(ext_pending & en_if.ext_q);

  // one level request, no priority encoding; core gates it with its
  // status word enable, so an unserviced request simply stays up
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      core_irq_o <= 1'b0;
    end else begin
      core_irq_o <= int_any | ext_any;
    end
  end

  // non-maskable path bypasses enables entirely
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      core_nmi_o <= 1'b0;
    end else begin
      core_nmi_o <= nmi_s2;
    end
  end

  // address decode: group base in bits 15..9, word offset in the low nine bits
  assign grp = addr_i & 16'hff00 & 16'hfeff;
  assign sub = addr_i - grp;
  // word within a group: internal word, then the two external words
  always_comb begin
    sub_int = 1'b0;
    sub_low = 1'b0;
    sub_high = 1'b0;
    unique case (sub)
      16'h0000: begin
        sub_int = 1'b1;
      end
      OFS_EXT_LOW: begin
        sub_low = 1'b1;
      end
      OFS_EXT_HIGH: begin
        sub_high = 1'b1;
      end
      default: begin
        sub_int = 1'b0;
      end
    endcase
  end

  // group role and kind of store; set and clear aliases let software
  // touch single bits without a read-modify-write
  always_comb begin
    is_pend = 1'b0;
    is_en = 1'b0;
    is_force = 1'b0;
    kind = WR_PLAIN;
    unique case (grp)
      OFS_PENDING_GROUP: begin
        is_pend = 1'b1;
      end
      OFS_ENABLE_GROUP: begin
        is_en = 1'b1;
      end
      OFS_ENABLE_SETTER: begin
        is_en = 1'b1;
        kind = WR_SET;
      end
      OFS_ENABLE_CLEARER: begin
        is_en = 1'b1;
        kind = WR_CLEAR;
      end
      OFS_FORCE_GROUP: begin
        is_force = 1'b1;
      end
      OFS_FORCE_SETTER: begin
        is_force = 1'b1;
        kind = WR_SET;
      end
      OFS_FORCE_CLEARER: begin
        is_force = 1'b1;
        kind = WR_CLEAR;
      end
      default: begin
        kind = WR_PLAIN;
      end
    endcase
  end

  // a hit needs both a known group and a known word
  assign sub_hit = sub_int || sub_low || sub_high;
  assign grp_hit = is_pend || is_en || is_force;
  assign hit = grp_hit && sub_hit;
  assign legal = hit && !cached_i && (size_i == SIZE_WORD);
  // a refused access never reaches a bank or the read mux
  assign wr_req = req_i && we_i && legal;
  assign rd_req = req_i && !we_i && legal;

  // stores to pending words are accepted and dropped (read-only)
  // both banks see every store; only the selected one takes it
  assign en_if.wr = wr_req && is_en;
  assign fo_if.wr = wr_req && is_force;
  assign en_if.kind = kind;
  assign fo_if.kind = kind;
  assign en_if.data = wdata_i;
  assign fo_if.data = wdata_i;
  assign en_if.sel_int = sub_int;
  assign en_if.sel_low = sub_low;
  assign en_if.sel_high = sub_high;
  assign fo_if.sel_int = sub_int;
  assign fo_if.sel_low = sub_low;
  assign fo_if.sel_high = sub_high;

  intc_bank enable_bank (
    .sys_clk_i(sys_clk_i),
    .nrst_i(nrst_i),
    .b(en_if.bank)
  );

  intc_bank force_bank (
    .sys_clk_i(sys_clk_i),
    .nrst_i(nrst_i),
    .b(fo_if.bank)
  );

  // word select inside a group; an unknown word never gets this far
  // because the load is refused
  always_comb begin
    if (sub_low) begin
      pend_word = ext_pending_q[31:0];
    end else if (sub_high) begin
      pend_word = ext_pending_q[63:32];
    end else begin
      pend_word = int_pending_q;
    end
  end

  // enable and force words, aliases included
  always_comb begin
    if (sub_low) begin
      en_word = en_if.ext_q[31:0];
    end else if (sub_high) begin
      en_word = en_if.ext_q[63:32];
    end else begin
      en_word = en_if.int_q;
    end
  end

  always_comb begin
    if (sub_low) begin
      fo_word = fo_if.ext_q[31:0];
    end else if (sub_high) begin
      fo_word = fo_if.ext_q[63:32];
    end else begin
      fo_word = fo_if.int_q;
    end
  end

  // aliases read back the register they steer; zero unless a load
  always_comb begin
    next_rdata = '0;
    if (rd_req) begin
      if (is_pend) begin
        next_rdata = pend_word;
      end else if (is_en) begin
        next_rdata = en_word;
      end else begin
        next_rdata = fo_word;
      end
    end
  end

  // answers are one-cycle pulses, one per request
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      ack_o <= 1'b0;
    end else begin
      ack_o <= req_i && legal;
    end
  end

  // every refused access answers with an error and changes nothing
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      err_o <= 1'b0;
    end else begin
      err_o <= req_i && !legal;
    end
  end

  // zero outside an accepted load so a stale word never leaks
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rdata_o <= REG_RESET;
    end else begin
      rdata_o <= next_rdata;
    end
  end
endmodule // normal_interrupt_aggregator

// ---- normal_interrupt_aggregator_sva.sv ----
// checker: bus answers and interrupt path timing at the top ports
// assumes one clock and the asynchronous active-low reset
`timescale 1ns/1ps
module nia_checker
  import intc_pkg::*;
(
  input wire logic sys_clk_i,
  input wire logic nrst_i,
  input wire logic [EXT_N-1:0] ext_irq_i,
  input wire logic timer_zero_source_i,
  input wire logic timer_one_source_i,
  input wire logic timer_two_source_i,
  input wire logic perf_monitor_source_i,
  input wire logic ext_ctrl_irq_i,
  input wire logic req_i,
  input wire logic we_i,
  input wire logic cached_i,
  input wire logic [1:0] size_i,
  input wire logic [ADDR_W-1:0] addr_i,
  input wire logic ack_o,
  input wire logic err_o,
  input wire logic [31:0] rdata_o,
  input wire logic core_irq_o,
  input wire logic core_nmi_o
);
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!nrst_i);
  logic src_any;
  logic wr_any;
  assign src_any = |{ext_irq_i, timer_zero_source_i, timer_one_source_i,
    timer_two_source_i, perf_monitor_source_i};
  assign wr_any = req_i && we_i;
  property p_answer; req_i |=> ack_o ^ err_o; endproperty
  a_answer: assert property (p_answer)
    else $error("not exactly one answer");
  property p_idle; !req_i |=> !ack_o && !err_o; endproperty
  a_idle: assert property (p_idle)
    else $error("answer without request");
  property p_cached; req_i && cached_i |=> err_o; endproperty
  a_cached: assert property (p_cached)
    else $error("cached access accepted");
  property p_size; req_i && size_i != SIZE_WORD |=> err_o; endproperty
  a_size: assert property (p_size)
    else $error("non-word access accepted");
  property p_pend_store; wr_any && !cached_i && size_i == SIZE_WORD &&
    addr_i == OFS_EXT_HIGH |=> ack_o; endproperty
  a_pend_store: assert property (p_pend_store)
    else $error("pending store refused");
  property p_resv; req_i && !we_i && addr_i[8:0] == 9'h000 |=>
    (rdata_o & ~INT_VALID_BITS) == 32'h0000_0000; endproperty
  a_resv: assert property (p_resv)
    else $error("reserved internal bit set");
  property p_nmi; ext_ctrl_irq_i [*3] |-> ##1 core_nmi_o; endproperty
  a_nmi: assert property (p_nmi)
    else $error("nmi not passed on");
  property p_irq_rise; $rose(core_irq_o) |->
    $past(src_any, 3) || $past(wr_any, 2); endproperty
  a_irq_rise: assert property (p_irq_rise)
    else $error("request without cause");
endmodule // nia_checker
bind normal_interrupt_aggregator nia_checker chk_i (.sys_clk_i, .nrst_i,
  .ext_irq_i, .timer_zero_source_i, .timer_one_source_i,
  .timer_two_source_i, .perf_monitor_source_i, .ext_ctrl_irq_i, .req_i,
  .we_i, .cached_i, .size_i, .addr_i, .ack_o, .err_o, .rdata_o,
  .core_irq_o, .core_nmi_o);

// ---- tb.sv ----
// testbench: register traffic, source levels and a core stand-in
// assumes each access is answered at the edge after it is taken
`timescale 1ns/1ps
module tb;
  import intc_pkg::*;
  logic sys_clk_i, nrst_i, req_i, we_i, cached_i, ext_ctrl_irq_i, ie;
  logic t0, t1, t2, pm, ack_o, err_o, core_irq_o, core_nmi_o;
  logic [EXT_N-1:0] ext_irq_i;
  logic [1:0] size_i;
  logic [ADDR_W-1:0] addr_i;
  logic [31:0] wdata_i, rdata_o;
  logic [31:0] en [3];
  logic [31:0] fo [3];
  logic [33:0] q [$];
  int err_total, n_compared, taken, nmi_taken, g, k;
  normal_interrupt_aggregator uut (.sys_clk_i, .nrst_i, .ext_irq_i,
    .timer_zero_source_i(t0), .timer_one_source_i(t1),
    .timer_two_source_i(t2), .perf_monitor_source_i(pm), .ext_ctrl_irq_i,
    .req_i, .we_i, .cached_i, .size_i, .addr_i, .wdata_i, .ack_o, .err_o,
    .rdata_o, .core_irq_o, .core_nmi_o);
  core_model core (.sys_clk_i, .nrst_i, .irq_i(core_irq_o),
    .nmi_i(core_nmi_o), .ie_i(ie), .taken_o(taken),
    .nmi_taken_o(nmi_taken));
  function automatic logic [15:0] ra(int gi, int ki);
    return 16'(gi * 512) | (ki == 0 ? 16'h0000 :
      (ki == 1 ? OFS_EXT_LOW : OFS_EXT_HIGH));
  endfunction
  function automatic logic [31:0] pend(int ki);
    if (ki == 0) return {15'h0, pm, 13'h0, t2, t1, t0} | fo[0];
    return (ki == 1 ? ext_irq_i[31:0] : ext_irq_i[63:32]) | fo[ki];
  endfunction
  function automatic logic [31:0] rval(int gi, int ki);
    case (gi)
      0: return pend(ki);
      1, 5, 6: return en[ki];
      default: return fo[ki];
    endcase
  endfunction
  task automatic chk(string nm, logic [31:0] e, logic [31:0] s);
    n_compared++;
    if (e !== s) begin
      err_total++;
      $display("wrong value %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic acc(logic w, logic c, logic [1:0] sz, logic [15:0] a,
      logic [31:0] d, logic e, logic [31:0] r);
    req_i = 1'h1;
    we_i = w;
    cached_i = c;
    size_i = sz;
    addr_i = a;
    wdata_i = d;
    q.push_back({!w && !e, e, r});
    @(posedge sys_clk_i);
    #1;
  endtask
  task automatic idle(int n);
    req_i = 1'h0;
    repeat (n) @(posedge sys_clk_i);
    #1;
  endtask
  task automatic wreg(int gi, int ki, logic [31:0] d);
    logic [31:0] m;
    m = (ki == 0) ? INT_VALID_BITS : 32'hffff_ffff;
    acc(1'h1, 1'h0, SIZE_WORD, ra(gi, ki), d, 1'h0, 32'h0000_0000);
    case (gi)
      1: en[ki] = d & m;
      2: fo[ki] = d & m;
      3: fo[ki] = fo[ki] | (d & m);
      4: fo[ki] = fo[ki] & ~d;
      5: en[ki] = en[ki] | (d & m);
      6: en[ki] = en[ki] & ~d;
      default: ;
    endcase
  endtask
  task automatic rreg(int gi, int ki);
    acc(1'h0, 1'h0, SIZE_WORD, ra(gi, ki), 32'h0, 1'h0, rval(gi, ki));
  endtask
  function automatic logic [31:0] irq_exp();
    return 32'(|((pend(0) & en[0]) | (pend(1) & en[1]) | (pend(2) & en[2])));
  endfunction
  task automatic report_and_stop();
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  initial begin
    sys_clk_i = 1'h0;
    forever #5 sys_clk_i = ~sys_clk_i;
  end
  // answers are matched in order; data only checked on accepted loads
  initial begin
    forever begin
      @(posedge sys_clk_i);
      #2;
      if (ack_o === 1'h1 || err_o === 1'h1) begin
        if (q.size() == 0) chk("stray answer", 32'h0, 32'h1);
        else begin
          chk("error flag", 32'(q[0][32]), 32'(err_o));
          if (q[0][33]) chk("read data", q[0][31:0], rdata_o);
          void'(q.pop_front());
        end
      end
    end
  end
  initial begin
    #500000;
    err_total++;
    report_and_stop();
  end
  initial begin
    {nrst_i, req_i, we_i, cached_i, ext_ctrl_irq_i, ie} = 6'h00;
    {t0, t1, t2, pm} = 4'h0;
    {size_i, addr_i, wdata_i, ext_irq_i} = {SIZE_WORD, 112'h0};
    en = '{3{32'h0}};
    fo = '{3{32'h0}};
    void'($urandom(4109));
    repeat (10) @(posedge sys_clk_i);
    #1;
    nrst_i = 1'h1;
    for (g = 0; g < 7; g++)
      for (k = 0; k < 3; k++) rreg(g, k);
    acc(1'h0, 1'h1, SIZE_WORD, 16'h0200, 32'h0, 1'h1, 32'h0);
    for (k = 0; k < 4; k++)
      if (k != 2) acc(1'h1, 1'h0, 2'(k), 16'h0200, '1, 1'h1, 32'h0);
    acc(1'h1, 1'h0, SIZE_WORD, 16'h0204, '1, 1'h1, 32'h0);
    acc(1'h0, 1'h0, SIZE_WORD, 16'h0e00, 32'h0, 1'h1, 32'h0);
    wreg(0, 2, 32'hffff_ffff);
    rreg(1, 0);
    rreg(0, 2);
    wreg(1, 0, 32'hffff_ffff);
    for (int i = 0; i < 80; i++) begin
      if (i % 8 == 0) begin
        ext_irq_i = {$urandom, $urandom};
        {t0, t1, t2, pm} = 4'($urandom);
      end
      wreg(1 + $urandom % 6, $urandom % 3, $urandom);
      idle(4);
      chk("core request", irq_exp(), 32'(core_irq_o));
      rreg($urandom % 7, $urandom % 3);
    end
    for (k = 0; k < 3; k++) begin
      wreg(6, k, 32'hffff_ffff);
      wreg(4, k, 32'hffff_ffff);
    end
    ext_irq_i = '1;
    {t0, t1, t2, pm, ext_ctrl_irq_i} = 5'h1f;
    idle(5);
    chk("masked request", 32'h0, 32'(core_irq_o));
    chk("nmi", 32'h1, 32'(core_nmi_o));
    chk("nmi taken", 32'h1, nmi_taken);
    {ext_irq_i, t0, t1, t2, pm, ext_ctrl_irq_i} = 69'h0;
    wreg(3, 0, 32'h0001_0000);
    wreg(5, 0, 32'h0001_0000);
    idle(4);
    chk("forced request", 32'h1, 32'(core_irq_o));
    rreg(0, 0);
    g = taken;
    idle(3);
    chk("taken while disabled", g, taken);
    ie = 1'h1;
    idle(2);
    chk("taken when enabled", g + 1, taken);
    idle(3);
    chk("answers outstanding", 32'h0, 32'(q.size()));
    report_and_stop();
  end
endmodule // tb
